// ==== design/pmx_params.svh ====
// Offsets, field positions, reset values and masks for the port pin mux.
// Assumes inclusion from the package, the mux module and the bench only.
`ifndef PMX_PARAMS_SVH
`define PMX_PARAMS_SVH

// Register byte offsets on the 32-bit APB slave, one aligned word each
`define PMX_OFF_DATA0 8'h00
`define PMX_OFF_DIR0 8'h14
`define PMX_STRIDE 8'h04
`define PMX_OFF_PUE_A 8'h28
`define PMX_OFF_PUE_C 8'h2C
`define PMX_OFF_PUE_D 8'h30
`define PMX_OFF_KBD_EN 8'h34
`define PMX_OFF_ADC_EN 8'h38
`define PMX_OFF_FUNC_D 8'h3C
`define PMX_OFF_FUNC_E 8'h40
`define PMX_OFF_INT_STAT 8'h44
`define PMX_OFF_INT_EN 8'h48
`define PMX_OFF_INT_CLR 8'h4C
`define PMX_OFF_CFG_STAT 8'h50

// Reset values
`define PMX_RST_BYTE 8'h00
`define PMX_RST_INT 2'h0
`define PMX_RST_WORD 32'h0000_0000

// Implemented bits per port
`define PMX_MASK_A 8'hFF
`define PMX_MASK_B 8'hFF
`define PMX_MASK_C_SMALL 8'h1F
`define PMX_MASK_C_LARGE 8'h7F
`define PMX_MASK_D 8'hFF
`define PMX_MASK_E 8'h1F

// Field positions
`define PMX_FD_SPI 0
`define PMX_FD_TIM_LO 4
`define PMX_FD_TIM_HI 7
`define PMX_FE_SCI 0
`define PMX_FE_OSC 1
`define PMX_INT_KBD 0
`define PMX_INT_IRQ 1
`define PMX_CFG_LARGE 0

// Port indices
`define PMX_PA 0
`define PMX_PB 1
`define PMX_PC 2
`define PMX_PD 3
`define PMX_PE 4

// Cycles after reset release before the package strap is taken
`define PMX_STRAP_WAIT 2'h2

`endif

// ==== design/pmx_pkg.sv ====
// Types shared by the port pin mux and whatever instantiates it.
// Assumes the constants header sits beside it.
`include "pmx_params.svh"

package pmx_pkg;

  typedef logic [7:0] pmx_byte_t;

  // Drive of one eight-bit pad group
  typedef struct packed {
    pmx_byte_t out;
    pmx_byte_t oe;
    pmx_byte_t pu;
  } pmx_pad_s;

  // Peripheral drive toward the pins
  typedef struct packed {
    logic [3:0] spi_out;
    logic [3:0] spi_oe;
    logic [3:0] tim_out;
    logic [3:0] tim_oe;
    logic sci_tx;
  } pmx_periph_drive_s;

  // Synchronised pin levels toward the peripherals
  typedef struct packed {
    logic [3:0] spi_in;
    logic [3:0] tim_in;
    logic sci_rx;
    pmx_byte_t kbd_level;
  } pmx_periph_sense_s;

  // Function selections toward the peripherals
  typedef struct packed {
    logic spi_sel;
    logic [3:0] tim_sel;
    logic sci_sel;
    logic osc_sel;
    pmx_byte_t kbd_en;
    pmx_byte_t adc_en;
  } pmx_pin_sel_s;

endpackage

// ==== design/pmx_port_mux.sv ====
// Port pin function mux: five ports, pull-ups, shared functions, reset and
// interrupt pins, APB register file. Assumes a 250 MHz clk, APB master on
// the same clock, and board pins resolved from out/oe/pu outside.
//
// Functional notes
// - A low level on the system reset pin resets the device and this block.
// - The reset pin is driven low while any internal reset source is active.
// - The interrupt pin is caught without the clock and has a pull-up.
// - Every pin of the first port can be a keyboard input, any subset at once.
// - A pull-up acts only while its pin is an input.
// - Each port pull-up has its own enable bit; the interrupt pin pull-up is always on.
// - Each pin of the second port is either general I/O or an analog input.
// - In the small package the two upper third-port bits are tied to ground.
// - Fourth port: low nibble to serial peripheral, each upper bit to a timer.
// - Fifth port bits zero and one can be serial transmit and receive.
// - Fifth port bits three and four can go to the clock generator.
// - All direction bits clear on reset so every pin starts as an input.
`timescale 1ns/10ps
`include "pmx_params.svh"

module pmx_port_mux
  import pmx_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins: index 0 port_one_keyboard_pins, 1 port_two_analog_pins,
  // 2 port_three_pins, 3 port_four_special_pins, 4 fifth port
  input wire logic [4:0][7:0] port_pins_in,
  output pmx_pad_s [4:0] port_pads,
  // Peripheral side
  input wire pmx_periph_drive_s periph_drive,
  output pmx_periph_sense_s periph_sense,
  output pmx_pin_sel_s pin_sel,
  // Reset pin and reset sources
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  input wire logic int_reset_req,
  output logic sys_reset_out,
  // Interrupt pin
  input wire logic irq_pin_n_in,
  output logic irq_pullup_en,
  output logic irq_req,
  // Package strap, high for the larger package
  input wire logic pkg_large_in,
  output logic int_out
);

  // Address match, used by every register select
  function automatic logic pmx_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic [4:0][7:0] pin_s1, pin_s2, pin_s3;
  logic rst_s1, rst_s2;
  logic irq_latch, irq_s1, irq_s2, irq_s3;
  logic strap_s1, strap_s2;
  logic [1:0] strap_cnt_reg;
  logic large_reg;
  pmx_byte_t data_reg [0:4];
  pmx_byte_t dir_reg [0:4];
  pmx_byte_t pue_a_reg, pue_c_reg, pue_d_reg, kbd_en_reg, adc_en_reg;
  pmx_byte_t func_d_reg, func_e_reg;
  logic [1:0] stat_reg, stat_next, en_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  pmx_pad_s [4:0] pad_reg;
  pmx_periph_sense_s sense_reg;
  logic rst_oe_reg, rst_lvl_reg, sys_reset_reg, irq_pu_reg, int_reg;

  // Pin synchronisers; stage one feeds stage two only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= port_pins_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Reset pin sampled; idles high so release does not re-trigger
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b1;
      rst_s2 <= 1'b1;
    end else begin
      rst_s1 <= rst_pin_in;
      rst_s2 <= rst_s1;
    end
  end

  wire pin_reset = ~rst_s2;

  // Reset pin drive and system reset request
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_oe_reg <= 1'b0;
      rst_lvl_reg <= 1'b0;
      sys_reset_reg <= 1'b1;
      irq_pu_reg <= 1'b1;
    end else begin
      rst_oe_reg <= int_reset_req;
      rst_lvl_reg <= 1'b0;
      sys_reset_reg <= int_reset_req | pin_reset;
      irq_pu_reg <= 1'b1;
    end
  end

  // Interrupt pin caught with no clock; held until the clock side sees it
  always_ff @(posedge clk or negedge reset_n or negedge irq_pin_n_in) begin
    if (!reset_n) begin
      irq_latch <= 1'b0;
    end else if (!irq_pin_n_in) begin
      irq_latch <= 1'b1;
    end else if (irq_s2) begin
      irq_latch <= 1'b0;
    end
  end

  // Latch brought onto clk; stage three only serves the edge detect
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
      irq_s3 <= 1'b0;
    end else begin
      irq_s1 <= irq_latch;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
    end
  end

  // Package strap followed once the count is up; stage two only settles then
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      strap_cnt_reg <= 2'h0;
      large_reg <= 1'b0;
    end else begin
      strap_s1 <= pkg_large_in;
      strap_s2 <= strap_s1;
      if (strap_cnt_reg != `PMX_STRAP_WAIT) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
      if (strap_cnt_reg == `PMX_STRAP_WAIT) begin
        large_reg <= strap_s2;
      end
    end
  end

  // Bus handshake: one wait cycle, pready high on the second access cycle
  wire acc = psel & penable;
  wire wr_go = acc & pready_reg & pwrite & pstrb[0];
  wire rd_take = acc & ~pready_reg & ~pwrite;

  // Implemented bits; missing third-port bits read as ground
  logic [4:0][7:0] mask;
  assign mask[`PMX_PA] = `PMX_MASK_A;
  assign mask[`PMX_PB] = `PMX_MASK_B;
  assign mask[`PMX_PC] = large_reg ? `PMX_MASK_C_LARGE : `PMX_MASK_C_SMALL;
  assign mask[`PMX_PD] = `PMX_MASK_D;
  assign mask[`PMX_PE] = `PMX_MASK_E;

  // Register selects
  wire hit_pue_a = pmx_hit(paddr, `PMX_OFF_PUE_A);
  wire hit_pue_c = pmx_hit(paddr, `PMX_OFF_PUE_C);
  wire hit_pue_d = pmx_hit(paddr, `PMX_OFF_PUE_D);
  wire hit_kbd = pmx_hit(paddr, `PMX_OFF_KBD_EN);
  wire hit_adc = pmx_hit(paddr, `PMX_OFF_ADC_EN);
  wire hit_fd = pmx_hit(paddr, `PMX_OFF_FUNC_D);
  wire hit_fe = pmx_hit(paddr, `PMX_OFF_FUNC_E);
  wire hit_stat = pmx_hit(paddr, `PMX_OFF_INT_STAT);
  wire hit_en = pmx_hit(paddr, `PMX_OFF_INT_EN);
  wire hit_clr = pmx_hit(paddr, `PMX_OFF_INT_CLR);
  wire hit_cfg = pmx_hit(paddr, `PMX_OFF_CFG_STAT);
  logic [4:0] hit_data, hit_dir;
  logic [4:0][7:0] rd_port;

  // Data and direction registers, one pair per port
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_port
      localparam logic [7:0] DOFF = 8'(`PMX_OFF_DATA0 + gi * `PMX_STRIDE);
      localparam logic [7:0] ROFF = 8'(`PMX_OFF_DIR0 + gi * `PMX_STRIDE);
      assign hit_data[gi] = pmx_hit(paddr, DOFF);
      assign hit_dir[gi] = pmx_hit(paddr, ROFF);
      // Outputs read their latch, inputs read the pin
      assign rd_port[gi] = ((data_reg[gi] & dir_reg[gi]) | (pin_s2[gi] & ~dir_reg[gi]))
                           & mask[gi];
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          data_reg[gi] <= `PMX_RST_BYTE;
          dir_reg[gi] <= `PMX_RST_BYTE;
        end else if (pin_reset) begin
          data_reg[gi] <= `PMX_RST_BYTE;
          dir_reg[gi] <= `PMX_RST_BYTE;
        end else begin
          if (wr_go && hit_data[gi]) begin
            data_reg[gi] <= pwdata[7:0] & mask[gi];
          end
          if (wr_go && hit_dir[gi]) begin
            dir_reg[gi] <= pwdata[7:0] & mask[gi];
          end
        end
      end
    end
  endgenerate

  // Control registers; a reset-pin low returns them to startup values
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pue_a_reg <= `PMX_RST_BYTE;
      pue_c_reg <= `PMX_RST_BYTE;
      pue_d_reg <= `PMX_RST_BYTE;
      kbd_en_reg <= `PMX_RST_BYTE;
      adc_en_reg <= `PMX_RST_BYTE;
      func_d_reg <= `PMX_RST_BYTE;
      func_e_reg <= `PMX_RST_BYTE;
      en_reg <= `PMX_RST_INT;
    end else if (pin_reset) begin
      pue_a_reg <= `PMX_RST_BYTE;
      pue_c_reg <= `PMX_RST_BYTE;
      pue_d_reg <= `PMX_RST_BYTE;
      kbd_en_reg <= `PMX_RST_BYTE;
      adc_en_reg <= `PMX_RST_BYTE;
      func_d_reg <= `PMX_RST_BYTE;
      func_e_reg <= `PMX_RST_BYTE;
      en_reg <= `PMX_RST_INT;
    end else if (wr_go) begin
      if (hit_pue_a) pue_a_reg <= pwdata[7:0];
      if (hit_pue_c) pue_c_reg <= pwdata[7:0] & mask[`PMX_PC];
      if (hit_pue_d) pue_d_reg <= pwdata[7:0];
      if (hit_kbd) kbd_en_reg <= pwdata[7:0];
      if (hit_adc) adc_en_reg <= pwdata[7:0];
      if (hit_fd) func_d_reg <= pwdata[7:0];
      if (hit_fe) func_e_reg <= pwdata[7:0];
      if (hit_en) en_reg <= pwdata[1:0];
    end
  end

  wire spi_sel = func_d_reg[`PMX_FD_SPI];
  wire [3:0] tim_sel = func_d_reg[`PMX_FD_TIM_HI:`PMX_FD_TIM_LO];
  wire sci_sel = func_e_reg[`PMX_FE_SCI];
  wire osc_sel = func_e_reg[`PMX_FE_OSC];

  // Effective pin drive: peripheral owns any pin given to it
  logic [4:0][7:0] eff_out, eff_oe, eff_pu;
  assign eff_out[`PMX_PA] = data_reg[`PMX_PA];
  assign eff_oe[`PMX_PA] = dir_reg[`PMX_PA] & ~kbd_en_reg;
  assign eff_out[`PMX_PB] = data_reg[`PMX_PB];
  assign eff_oe[`PMX_PB] = dir_reg[`PMX_PB] & ~adc_en_reg;
  assign eff_out[`PMX_PC] = data_reg[`PMX_PC];
  assign eff_oe[`PMX_PC] = dir_reg[`PMX_PC] & mask[`PMX_PC];
  // Serial peripheral takes the low nibble, timers each upper bit
  assign eff_out[`PMX_PD] = {(tim_sel & periph_drive.tim_out)
                             | (~tim_sel & data_reg[`PMX_PD][7:4]),
                             spi_sel ? periph_drive.spi_out : data_reg[`PMX_PD][3:0]};
  assign eff_oe[`PMX_PD] = {(tim_sel & periph_drive.tim_oe)
                            | (~tim_sel & dir_reg[`PMX_PD][7:4]),
                            spi_sel ? periph_drive.spi_oe : dir_reg[`PMX_PD][3:0]};
  // Transmit drives bit 0, receive and oscillator pins are inputs
  assign eff_out[`PMX_PE] = {data_reg[`PMX_PE][7:1],
                             sci_sel ? periph_drive.sci_tx : data_reg[`PMX_PE][0]};
  assign eff_oe[`PMX_PE] = {3'h0, osc_sel ? 2'h0 : dir_reg[`PMX_PE][4:3],
                            dir_reg[`PMX_PE][2],
                            sci_sel ? 1'b0 : dir_reg[`PMX_PE][1],
                            sci_sel ? 1'b1 : dir_reg[`PMX_PE][0]};

  // Pull-ups off on any driven pin, and on ports that have none
  assign eff_pu[`PMX_PA] = pue_a_reg & ~eff_oe[`PMX_PA];
  assign eff_pu[`PMX_PB] = 8'h00;
  assign eff_pu[`PMX_PC] = pue_c_reg & ~eff_oe[`PMX_PC] & mask[`PMX_PC];
  assign eff_pu[`PMX_PD] = pue_d_reg & ~eff_oe[`PMX_PD];
  assign eff_pu[`PMX_PE] = 8'h00;

  // Events: keyboard falling edge on an enabled pin, interrupt pin caught
  wire kbd_evt = |(kbd_en_reg & pin_s3[`PMX_PA] & ~pin_s2[`PMX_PA]);
  wire irq_evt = irq_s2 & ~irq_s3;
  wire [1:0] clr_bits = (wr_go && hit_clr) ? pwdata[1:0] : 2'h0;
  wire [1:0] evt_bits = {irq_evt, kbd_evt};
  // Set wins over a clear in the same cycle
  assign stat_next = (stat_reg & ~clr_bits) | evt_bits;

  // Read mux; unmapped addresses read zero
  logic [7:0] rd_byte;
  logic hit_any;
  always_comb begin
    rd_byte = 8'h00;
    for (int i = 0; i < 5; i++) begin
      if (hit_data[i]) rd_byte = rd_port[i];
      if (hit_dir[i]) rd_byte = dir_reg[i];
    end
    if (hit_pue_a) rd_byte = pue_a_reg;
    if (hit_pue_c) rd_byte = pue_c_reg;
    if (hit_pue_d) rd_byte = pue_d_reg;
    if (hit_kbd) rd_byte = kbd_en_reg;
    if (hit_adc) rd_byte = adc_en_reg;
    if (hit_fd) rd_byte = func_d_reg;
    if (hit_fe) rd_byte = func_e_reg;
    if (hit_stat) rd_byte = {6'h00, stat_reg};
    if (hit_en) rd_byte = {6'h00, en_reg};
    if (hit_cfg) rd_byte = {7'h00, large_reg};
    hit_any = (|hit_data) | (|hit_dir) | hit_pue_a | hit_pue_c | hit_pue_d | hit_kbd
              | hit_adc | hit_fd | hit_fe | hit_stat | hit_en | hit_clr | hit_cfg;
  end

  // Bus answer registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= `PMX_RST_WORD;
    end else begin
      pready_reg <= acc & ~pready_reg;
      pslverr_reg <= acc & ~pready_reg & ~hit_any;
      if (rd_take) begin
        prdata_reg <= {24'h000000, rd_byte};
      end
    end
  end

  // Status, interrupt line, pads and sensed levels
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_reg <= `PMX_RST_INT;
      int_reg <= 1'b0;
      pad_reg <= '0;
      sense_reg <= '0;
    end else begin
      stat_reg <= pin_reset ? `PMX_RST_INT : stat_next;
      int_reg <= ~pin_reset & |(stat_next & en_reg);
      for (int i = 0; i < 5; i++) begin
        pad_reg[i] <= pin_reset ? '0 : {eff_out[i] & mask[i], eff_oe[i] & mask[i], eff_pu[i]};
      end
      sense_reg.spi_in <= pin_s2[`PMX_PD][3:0];
      sense_reg.tim_in <= pin_s2[`PMX_PD][7:4];
      sense_reg.sci_rx <= pin_s2[`PMX_PE][1];
      sense_reg.kbd_level <= pin_s2[`PMX_PA] | ~kbd_en_reg;
    end
  end

  // Output connections, all from flip-flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign port_pads = pad_reg;
  assign periph_sense = sense_reg;
  assign pin_sel = {func_d_reg[`PMX_FD_SPI], func_d_reg[`PMX_FD_TIM_HI:`PMX_FD_TIM_LO],
                    func_e_reg[`PMX_FE_SCI], func_e_reg[`PMX_FE_OSC], kbd_en_reg, adc_en_reg};
  assign rst_pin_out = rst_lvl_reg;
  assign rst_pin_oe = rst_oe_reg;
  assign sys_reset_out = sys_reset_reg;
  assign irq_pullup_en = irq_pu_reg;
  assign irq_req = irq_s2;
  assign int_out = int_reg;

endmodule

// ==== test/pmx_board_model.sv ====
// Board model: resolves port, reset and interrupt pin levels.
// Assumes the bench sets external drive per bit through ext_en and ext_val.
`timescale 1ns/10ps
module pmx_board_model
  import pmx_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire pmx_pad_s [4:0] port_pads,
  input wire logic [4:0][7:0] ext_en,
  input wire logic [4:0][7:0] ext_val,
  input wire logic rst_pin_oe,
  input wire logic rst_pin_out,
  input wire logic ext_rst_low,
  input wire logic irq_pullup_en,
  input wire logic ext_irq_low,
  output logic [4:0][7:0] pins,
  output logic rst_pin,
  output logic irq_pin_n
);
  logic [4:0][7:0] last_reg;
  logic irq_last_reg;

  // Floating pins toggle, so a stale level never looks like a drive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_reg <= '0;
      irq_last_reg <= 1'b0;
    end else begin
      last_reg <= pins;
      irq_last_reg <= irq_pin_n;
    end
  end

  // Device drive wins, then board drive, then pull-up
  always_comb begin
    for (int p = 0; p < 5; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (port_pads[p].oe[b]) pins[p][b] = port_pads[p].out[b];
        else if (ext_en[p][b]) pins[p][b] = ext_val[p][b];
        else if (port_pads[p].pu[b]) pins[p][b] = 1'b1;
        else pins[p][b] = ~last_reg[p][b];
      end
    end
  end

  // Reset pin pulled up, low when either side pulls it
  assign rst_pin = (rst_pin_oe ? rst_pin_out : 1'b1) & ~ext_rst_low;
  // Interrupt pin idles high only through the device pull-up
  assign irq_pin_n = ext_irq_low ? 1'b0 : (irq_pullup_en ? 1'b1 : ~irq_last_reg);
endmodule

// ==== test/pmx_port_mux_monitor.sv ====
// Checker for the port pin mux, watching only its top-level ports.
// Assumes one clock domain and a bench that never pulls reset pin mid-function.
`timescale 1ns/10ps
module pmx_port_mux_monitor
  import pmx_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire pmx_pad_s [4:0] port_pads,
  input wire pmx_periph_drive_s periph_drive,
  input wire pmx_pin_sel_s pin_sel,
  input wire logic rst_pin_in,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire logic int_reset_req,
  input wire logic sys_reset_out,
  input wire logic irq_pullup_en,
  input wire logic pkg_large_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Bus answer timing and pad behaviour
  a_apb_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_rst_pin_pull: assert property (int_reset_req |=> rst_pin_oe && !rst_pin_out)
    else $error("reset pin not pulled low");
  a_rst_pin_in: assert property (!rst_pin_in [*4] |=> sys_reset_out && port_pads[0].oe == 8'h00)
    else $error("reset pin low did not reset");
  a_irq_pull_on: assert property (irq_pullup_en)
    else $error("interrupt pull-up off");
  a_pull_only_in: assert property (((port_pads[0].oe & port_pads[0].pu)
    | (port_pads[2].oe & port_pads[2].pu) | (port_pads[3].oe & port_pads[3].pu)) == 8'h00)
    else $error("pull-up on a driven pin");
  a_kbd_forced_in: assert property ((port_pads[0].oe & $past(pin_sel.kbd_en)) == 8'h00)
    else $error("keyboard pin driven");
  a_adc_forced_in: assert property ((port_pads[1].oe & $past(pin_sel.adc_en)) == 8'h00)
    else $error("analog pin driven");
  a_small_pkg_tie: assert property (!pkg_large_in |-> port_pads[2].oe[7:5] == 3'h0)
    else $error("absent port three bit driven");
  a_spi_tim_follow: assert property ($past(pin_sel.spi_sel) && $past(pin_sel.tim_sel) == 4'hF
    |-> port_pads[3].oe == {$past(periph_drive.tim_oe), $past(periph_drive.spi_oe)})
    else $error("fourth port not following peripherals");
  a_sci_tx_follow: assert property ($past(pin_sel.sci_sel)
    |-> port_pads[4].oe[1:0] == 2'h1 && port_pads[4].out[0] == $past(periph_drive.sci_tx))
    else $error("serial pins wrong");
  a_osc_released: assert property ($past(pin_sel.osc_sel)
    |-> (port_pads[4].oe[4:3] | port_pads[4].pu[4:3]) == 2'h0)
    else $error("oscillator pins driven");
  a_dir_clear_start: assert property (!$past(reset_n) |-> {port_pads[0].oe, port_pads[1].oe,
    port_pads[2].oe, port_pads[3].oe, port_pads[4].oe} == 40'h0)
    else $error("pin driven right after reset");
endmodule

bind pmx_port_mux pmx_port_mux_monitor pmx_port_mux_monitor_i (.clk(clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pready(pready), .port_pads(port_pads),
  .periph_drive(periph_drive), .pin_sel(pin_sel), .rst_pin_in(rst_pin_in),
  .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .int_reset_req(int_reset_req),
  .sys_reset_out(sys_reset_out), .irq_pullup_en(irq_pullup_en), .pkg_large_in(pkg_large_in));

// ==== test/tb_pmx_port_mux.sv ====
// Bench for the port pin mux: APB master tasks, board model, scenarios.
// Assumes the small package strap until the last scenario, drive set from here.
`timescale 1ns/10ps
`include "pmx_params.svh"
module tb_pmx_port_mux
  import pmx_pkg::*;
;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic [4:0][7:0] pins, ext_en, ext_val;
  pmx_pad_s [4:0] port_pads;
  pmx_periph_drive_s periph_drive;
  pmx_periph_sense_s periph_sense;
  pmx_pin_sel_s pin_sel;
  logic rst_pin, rst_pin_out, rst_pin_oe, int_reset_req, sys_reset_out, pkg_large_in;
  logic irq_pin_n, irq_pullup_en, irq_req, int_out, ext_rst_low, ext_irq_low;
  int bad_count, checked;

  pmx_port_mux pmx_port_mux_i (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_pins_in(pins), .port_pads(port_pads),
    .periph_drive(periph_drive), .periph_sense(periph_sense), .pin_sel(pin_sel),
    .rst_pin_in(rst_pin), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .int_reset_req(int_reset_req), .sys_reset_out(sys_reset_out), .irq_pin_n_in(irq_pin_n),
    .irq_pullup_en(irq_pullup_en), .irq_req(irq_req), .pkg_large_in(pkg_large_in),
    .int_out(int_out));
  pmx_board_model pmx_board_model_i (.clk(clk), .reset_n(reset_n), .port_pads(port_pads),
    .ext_en(ext_en), .ext_val(ext_val), .rst_pin_oe(rst_pin_oe), .rst_pin_out(rst_pin_out),
    .ext_rst_low(ext_rst_low), .irq_pullup_en(irq_pullup_en), .ext_irq_low(ext_irq_low),
    .pins(pins), .rst_pin(rst_pin), .irq_pin_n(irq_pin_n));

  // Free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready, no assumed latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    // One more edge so pads launched by the write have settled
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    chk("read data", rdat, {24'h0, e});
  endtask

  task automatic pad(input int p, input logic [7:0] oe, input logic [7:0] pu);
    chk("pad oe", port_pads[p].oe, oe);
    chk("pad pu", port_pads[p].pu, pu);
  endtask

  task automatic s_start;
    for (int i = 0; i < 5; i++) rd(`PMX_OFF_DIR0 + 8'(4 * i), 8'h00);
    apb(1'b0, 8'hFC, 32'h0);
    chk("unmapped error", rerr, 1'b1);
    rd(`PMX_OFF_CFG_STAT, 8'h00);
    wr(`PMX_OFF_DIR0 + 8'h08, 8'hFF);
    rd(`PMX_OFF_DIR0 + 8'h08, 8'h1F);
    pad(2, 8'h1F, 8'h00);
  endtask

  task automatic s_reset_pin;
    wr(`PMX_OFF_DIR0, 8'hFF);
    int_reset_req <= 1'b1;
    tick(3);
    chk("reset pin oe", rst_pin_oe, 1'b1);
    chk("reset pin level", rst_pin, 1'b0);
    tick(4);
    chk("system reset", sys_reset_out, 1'b1);
    int_reset_req <= 1'b0;
    tick(8);
    rd(`PMX_OFF_DIR0, 8'h00);
    ext_rst_low <= 1'b1;
    tick(6);
    chk("system reset", sys_reset_out, 1'b1);
    ext_rst_low <= 1'b0;
    tick(6);
    chk("system reset", sys_reset_out, 1'b0);
  endtask

  task automatic s_pullups;
    wr(`PMX_OFF_PUE_A, 8'h0F);
    wr(`PMX_OFF_DIR0, 8'h03);
    pad(0, 8'h03, 8'h0C);
    wr(`PMX_OFF_PUE_D, 8'h81);
    wr(`PMX_OFF_DIR0 + 8'h0C, 8'h01);
    pad(3, 8'h01, 8'h80);
  endtask

  // Keyboard event raised, cleared, then masked
  task automatic s_kbd;
    ext_en[0] <= 8'hFF;
    ext_val[0] <= 8'hFF;
    wr(`PMX_OFF_DIR0, 8'hFF);
    wr(`PMX_OFF_KBD_EN, 8'hFF);
    wr(`PMX_OFF_INT_EN, 8'h01);
    wr(`PMX_OFF_INT_CLR, 8'h03);
    chk("kbd oe", port_pads[0].oe, 8'h00);
    ext_val[0] <= 8'hDF;
    tick(8);
    chk("int out", int_out, 1'b1);
    chk("kbd level", periph_sense.kbd_level, 8'hDF);
    rd(`PMX_OFF_INT_STAT, 8'h01);
    wr(`PMX_OFF_INT_CLR, 8'h01);
    tick(2);
    chk("int out", int_out, 1'b0);
    wr(`PMX_OFF_INT_EN, 8'h00);
    ext_val[0] <= 8'hDE;
    tick(8);
    chk("int out", int_out, 1'b0);
    rd(`PMX_OFF_INT_STAT, 8'h01);
  endtask

  task automatic s_irq;
    wr(`PMX_OFF_INT_CLR, 8'h03);
    wr(`PMX_OFF_INT_EN, 8'h02);
    ext_irq_low <= 1'b1;
    tick(6);
    chk("irq req", irq_req, 1'b1);
    chk("int out", int_out, 1'b1);
    ext_irq_low <= 1'b0;
    tick(4);
    wr(`PMX_OFF_INT_CLR, 8'h02);
    tick(2);
    chk("int out", int_out, 1'b0);
    chk("irq req", irq_req, 1'b0);
  endtask

  task automatic s_adc;
    wr(`PMX_OFF_DIR0 + 8'h04, 8'hFF);
    wr(`PMX_OFF_ADC_EN, 8'h0F);
    pad(1, 8'hF0, 8'h00);
    chk("adc sel", pin_sel.adc_en, 8'h0F);
    wr(`PMX_OFF_ADC_EN, 8'h00);
    pad(1, 8'hFF, 8'h00);
  endtask

  // Peripherals take fourth and fifth port pins; only the fourth port's are given back
  task automatic s_funcs;
    periph_drive <= '{spi_out: 4'hA, spi_oe: 4'h5, tim_out: 4'h3, tim_oe: 4'hC, sci_tx: 1'b1};
    wr(`PMX_OFF_DIR0 + 8'h0C, 8'hFF);
    wr(`PMX_OFF_FUNC_D, 8'hF1);
    chk("d oe", port_pads[3].oe, 8'hC5);
    chk("d out", port_pads[3].out, 8'h3A);
    wr(`PMX_OFF_FUNC_D, 8'h00);
    chk("d oe", port_pads[3].oe, 8'hFF);
    wr(`PMX_OFF_DATA0 + 8'h0C, 8'h5A);
    tick(3);
    chk("d sense", {periph_sense.tim_in, periph_sense.spi_in}, 8'h5A);
    ext_en[4] <= 8'h02;
    ext_val[4] <= 8'h00;
    wr(`PMX_OFF_DIR0 + 8'h10, 8'h1F);
    wr(`PMX_OFF_FUNC_E, 8'h03);
    tick(3);
    pad(4, 8'h05, 8'h00);
    chk("tx out", port_pads[4].out[0], 1'b1);
    chk("rx in", periph_sense.sci_rx, 1'b0);
    ext_val[4] <= 8'h02;
    tick(5);
    chk("rx in", periph_sense.sci_rx, 1'b1);
  endtask

  // Larger package strap taken after a fresh reset
  task automatic s_large;
    pkg_large_in <= 1'b1;
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    tick(4);
    rd(`PMX_OFF_CFG_STAT, 8'h01);
    wr(`PMX_OFF_DIR0 + 8'h08, 8'hFF);
    rd(`PMX_OFF_DIR0 + 8'h08, 8'h7F);
    pad(2, 8'h7F, 8'h00);
  endtask

  // Main sequence
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    {ext_en, ext_val} = '0;
    periph_drive = '0;
    {int_reset_req, ext_rst_low, ext_irq_low, pkg_large_in} = 4'h0;
    bad_count = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    tick(3);
    s_start;
    s_reset_pin;
    s_pullups;
    s_kbd;
    s_irq;
    s_adc;
    s_funcs;
    s_large;
    finish_test;
  end

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test;
  end
endmodule
